/* logic/limit_monitor_pkg.sv */
/*
  Shared constants and carriers for the current and temperature limit monitor:
  command codes, status bit positions, reset values and linear-format layout.
  Assumes a command engine that decodes host transactions into cmd_req_t words.
*/
package limit_monitor_pkg;

  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS      = 8'h03;
  localparam logic [7:0] CMD_IOUT_WARN_LIMIT   = 8'h4A;
  localparam logic [7:0] CMD_TEMP_FAULT_LIMIT  = 8'h4F;
  localparam logic [7:0] CMD_TEMP_FAULT_ACTION = 8'h50;
  localparam logic [7:0] CMD_STATUS_BYTE       = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD       = 8'h79;
  localparam logic [7:0] CMD_STATUS_IOUT       = 8'h7B;
  localparam logic [7:0] CMD_STATUS_TEMP       = 8'h7D;

  // Reset and fixed values
  localparam logic [15:0] TEMP_LIMIT_RESET  = 16'h007D;
  localparam logic [7:0]  TEMP_ACTION_VALUE = 8'hF8;

  // Linear format layout
  localparam int          EXP_MSB    = 15;
  localparam int          EXP_LSB    = 11;
  localparam int          MANT_MSB   = 10;
  localparam int          MANT_LSB   = 0;
  localparam int          MANT_WIDTH = 11;
  localparam int          FRAC_BITS  = 16;
  localparam int          FIXED_WIDTH = 48;
  localparam logic [4:0]  EXP_BIAS   = 5'h10;

  // Restart hysteresis in degrees Celsius
  localparam int HYST_DEGREES = 15;
  localparam logic signed [FIXED_WIDTH-1:0] HYST_FIXED =
    FIXED_WIDTH'(HYST_DEGREES) <<< FRAC_BITS;

  // Status bit positions
  localparam int SB_OTHER_BIT   = 0;
  localparam int SB_TEMP_BIT    = 2;
  localparam int SW_IOUT_BIT    = 14;
  localparam int SI_WARN_BIT    = 5;
  localparam int ST_FAULT_BIT   = 7;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] value;
  } telemetry_t;

endpackage : limit_monitor_pkg

/* logic/linear_to_fixed.sv */
/*
  Converts one linear-format word into a signed fixed-point value with
  FRAC_BITS fraction bits, exact for every exponent from -16 to 15.
  Purely combinational; the caller registers what it needs.
*/
`timescale 1ns/1ps
module linear_to_fixed
  import limit_monitor_pkg::*;
(
  input  wire logic [15:0]                    linear_value,
  output logic signed [FIXED_WIDTH-1:0]       fixed_value
);

  logic [4:0]            shift;
  logic [MANT_WIDTH-1:0] mant;

  // Exponent plus sixteen, modulo thirty-two
  assign shift = linear_value[EXP_MSB:EXP_LSB] ^ EXP_BIAS;
  assign mant  = linear_value[MANT_MSB:MANT_LSB];
  assign fixed_value =
    {{(FIXED_WIDTH-MANT_WIDTH){mant[MANT_WIDTH-1]}}, mant} <<< shift;

endmodule : linear_to_fixed

/* logic/current_temp_limit_monitor.sv */
/*
  Limit registers, sticky status bits, alert and fault pins, and the
  over-temperature shutdown with restart hysteresis.
  Assumes commands, telemetry and the current default all come from logic
  on core_clk; ce low freezes every state element, but reset still acts while ce is low.
*/
`timescale 1ns/1ps
module current_temp_limit_monitor
  import limit_monitor_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire cmd_req_t    cmd,
  output logic [15:0]      cmd_rdata,
  output logic             cmd_rvalid,
  input  wire telemetry_t  iout_tel,
  input  wire telemetry_t  temp_tel,
  input  wire logic [15:0] max_current_setting,
  output logic             alert_output_pin,
  output logic             regulator_fault_pin,
  output logic             output_enable
);

  logic [15:0] output_current_warn_threshold;
  logic [15:0] temperature_fault_threshold;
  logic        default_pending;
  logic        iout_warn;
  logic        temp_fault;

  logic [15:0] linear_in [4];
  logic signed [FIXED_WIDTH-1:0] fixed_out [4];

  assign linear_in[0] = iout_tel.value;
  assign linear_in[1] = output_current_warn_threshold;
  assign linear_in[2] = temp_tel.value;
  assign linear_in[3] = temperature_fault_threshold;

  for (genvar g = 0; g < 4; g++) begin : g_conv
    linear_to_fixed u_conv (
      .linear_value (linear_in[g]),
      .fixed_value  (fixed_out[g])
    );
  end

  logic wr_en;
  logic rd_en;
  logic clear_cmd;
  logic warn_set;
  logic temp_set;
  logic restart_ok;
  logic next_iout_warn;
  logic next_temp_fault;

  assign wr_en     = cmd.valid && cmd.write;
  assign rd_en     = cmd.valid && !cmd.write;
  assign clear_cmd = wr_en && (cmd.code == CMD_CLEAR_FAULTS);

  assign warn_set   = iout_tel.valid && (fixed_out[0] > fixed_out[1]);
  assign temp_set   = temp_tel.valid && (fixed_out[2] > fixed_out[3]);
  assign restart_ok = temp_tel.valid && (fixed_out[2] <= fixed_out[3] - HYST_FIXED);

  assign next_iout_warn  = warn_set || (iout_warn && !clear_cmd);
  assign next_temp_fault = temp_set || (temp_fault && !clear_cmd);

  // warning threshold write, default from current setting
  always_ff @(posedge core_clk) begin
    if (reset) begin
      output_current_warn_threshold <= 16'h0000;
      default_pending               <= 1'b1;
    end else if (ce) begin
      default_pending <= 1'b0;
      if (wr_en && cmd.code == CMD_IOUT_WARN_LIMIT) begin
        output_current_warn_threshold <= cmd.wdata;
      end else if (default_pending) begin
        output_current_warn_threshold <= max_current_setting;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      temperature_fault_threshold <= TEMP_LIMIT_RESET;
    end else if (ce && wr_en && cmd.code == CMD_TEMP_FAULT_LIMIT) begin
      temperature_fault_threshold <= cmd.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      iout_warn        <= 1'b0;
      temp_fault       <= 1'b0;
      alert_output_pin <= 1'b0;
    end else if (ce) begin
      iout_warn        <= next_iout_warn;
      temp_fault       <= next_temp_fault;
      alert_output_pin <= next_iout_warn || next_temp_fault;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      regulator_fault_pin <= 1'b0;
    end else if (ce) begin
      regulator_fault_pin <= next_temp_fault;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      output_enable <= 1'b1;
    end else if (ce) begin
      if (temp_set) begin
        output_enable <= 1'b0;
      end else if (!output_enable && restart_ok) begin
        output_enable <= 1'b1;
      end
    end
  end

  logic [7:0] status_byte;
  assign status_byte = 8'((iout_warn  ? 1 << SB_OTHER_BIT : 0)
                        | (temp_fault ? 1 << SB_TEMP_BIT  : 0));

  // Read port, one cycle latency
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_rdata  <= 16'h0000;
      cmd_rvalid <= 1'b0;
    end else if (ce) begin
      cmd_rvalid <= rd_en;
      if (rd_en) begin
        case (cmd.code)
          CMD_IOUT_WARN_LIMIT:   cmd_rdata <= output_current_warn_threshold;
          CMD_TEMP_FAULT_LIMIT:  cmd_rdata <= temperature_fault_threshold;
          CMD_TEMP_FAULT_ACTION: cmd_rdata <= {8'h00, TEMP_ACTION_VALUE};
          CMD_STATUS_BYTE:       cmd_rdata <= {8'h00, status_byte};
          CMD_STATUS_WORD:       cmd_rdata <= 16'({8'h00, status_byte}
                                          | (iout_warn ? 1 << SW_IOUT_BIT : 0));
          CMD_STATUS_IOUT:       cmd_rdata <= 16'(iout_warn ? 1 << SI_WARN_BIT : 0);
          CMD_STATUS_TEMP:       cmd_rdata <= 16'(temp_fault ? 1 << ST_FAULT_BIT : 0);
          default:               cmd_rdata <= 16'h0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  warn_sets_alert_a: assert property (ce && warn_set |=> iout_warn && alert_output_pin)
    else $error("current warning did not set status and alert");
  no_false_warn_a: assert property (ce && !warn_set && !iout_warn |=> !iout_warn)
    else $error("current warning set without a sample above limit");
  warn_word_bit_a: assert property (ce && rd_en && cmd.code == CMD_STATUS_WORD
      && iout_warn && !clear_cmd |=> cmd_rdata[SW_IOUT_BIT] && cmd_rdata[SB_OTHER_BIT])
    else $error("status word lacks current bits");
  warn_write_a: assert property (ce && wr_en && cmd.code == CMD_IOUT_WARN_LIMIT
      |=> output_current_warn_threshold == $past(cmd.wdata))
    else $error("warning threshold write lost");
  warn_read_a: assert property (ce && rd_en && cmd.code == CMD_IOUT_WARN_LIMIT
      |=> cmd_rvalid && cmd_rdata == $past(output_current_warn_threshold))
    else $error("warning threshold read wrong");

  linear_exp0_a: assert property (temperature_fault_threshold[EXP_MSB:EXP_LSB] == 5'h00
      |-> fixed_out[3] == (FIXED_WIDTH'(signed'(temperature_fault_threshold[MANT_MSB:0]))
      <<< FRAC_BITS))
    else $error("linear decode wrong for zero exponent");

  temp_reset_a: assert property (disable iff (1'b0) reset && ce
      |=> temperature_fault_threshold == TEMP_LIMIT_RESET)
    else $error("temperature threshold reset value wrong");
  temp_write_a: assert property (ce && wr_en && cmd.code == CMD_TEMP_FAULT_LIMIT
      |=> temperature_fault_threshold == $past(cmd.wdata))
    else $error("temperature threshold write lost");
  temp_fault_pins_a: assert property (ce && temp_set
      |=> temp_fault && alert_output_pin && regulator_fault_pin)
    else $error("over-temperature did not raise pins");
  temp_shutdown_a: assert property (ce && temp_set |=> !output_enable)
    else $error("output not disabled on over-temperature");
  restart_hyst_a: assert property ($rose(output_enable) && !$past(reset)
      |-> $past(restart_ok))
    else $error("restart without hysteresis");
  hold_off_a: assert property (ce && !output_enable && !restart_ok
      |=> !output_enable)
    else $error("output restarted above hysteresis");

  action_read_a: assert property (ce && rd_en && cmd.code == CMD_TEMP_FAULT_ACTION
      |=> cmd_rvalid && cmd_rdata == 16'h00F8)
    else $error("fault action value wrong");

  status_sticky_a: assert property (ce && iout_warn && !clear_cmd |=> iout_warn)
    else $error("status bit dropped without clear");
  temp_sticky_a: assert property (ce && temp_fault && !clear_cmd |=> temp_fault)
    else $error("temperature status dropped without clear");
  clear_drops_a: assert property (ce && clear_cmd && !warn_set && !temp_set
      |=> !alert_output_pin && !regulator_fault_pin)
    else $error("clear did not drop alert and fault pin");
  freeze_hold_a: assert property (!ce |=> $stable(temperature_fault_threshold)
      && $stable(output_enable) && $stable(alert_output_pin))
    else $error("state moved while clock enable low");

  warn_event_c: cover property (ce && warn_set ##1 alert_output_pin);
  shutdown_restart_c: cover property ($fell(output_enable) ##[1:200] $rose(output_enable));
  clear_c: cover property (ce && clear_cmd && temp_fault ##1 !temp_fault);
  freeze_c: cover property (!ce && temp_tel.valid);
  hyst_hold_c: cover property (!output_enable && temp_tel.valid && !temp_set && !restart_ok);

endmodule : current_temp_limit_monitor

/* testbench/host_model.sv */
/*
  Host side model: issues command words and telemetry samples to the monitor.
  Assumes every task is entered right after a rising edge of core_clk.
*/
`timescale 1ns/1ps
module host_model
  import limit_monitor_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [15:0] cmd_rdata,
  input  wire logic        cmd_rvalid,
  output cmd_req_t         cmd,
  output telemetry_t       iout_tel,
  output telemetry_t       temp_tel
);
  initial begin
    cmd = '0;
    iout_tel = '0;
    temp_tel = '0;
  end

  // One-cycle command pulse, then one idle edge
  task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] d);
    cmd <= '{1'b1, wr, code, d};
    @(posedge core_clk);
    cmd <= '0;
    @(posedge core_clk);
  endtask : send

  // Read data taken while the one-cycle answer stands
  task automatic read(input logic [7:0] code, output logic [15:0] d);
    cmd <= '{1'b1, 1'b0, code, 16'h0000};
    @(posedge core_clk);
    cmd <= '0;
    #1;
    d = (cmd_rvalid === 1'b1) ? cmd_rdata : 'x;
    @(posedge core_clk);
  endtask : read

  task automatic sample(input logic is_temp, input logic [15:0] v);
    if (is_temp) temp_tel <= '{1'b1, v};
    else iout_tel <= '{1'b1, v};
    @(posedge core_clk);
    temp_tel <= '0;
    iout_tel <= '0;
  endtask : sample
endmodule : host_model

/* testbench/current_temp_limit_monitor_bench.sv */
/*
  Bench for the limit monitor: register access, warning and over-temperature runs.
  Assumes host_model makes every request on the command and telemetry ports.
*/
`timescale 1ns/1ps
module current_temp_limit_monitor_bench;
  import limit_monitor_pkg::*;
  logic        core_clk, reset, ce, alert, fault_pin, oe, rvalid;
  logic [15:0] rdata, rd;
  cmd_req_t    cmd;
  telemetry_t  iout_tel, temp_tel;
  int          bad_count = 0;
  int          checked = 0;

  current_temp_limit_monitor dut_u (.core_clk(core_clk), .reset(reset), .ce(ce), .cmd(cmd),
    .cmd_rdata(rdata), .cmd_rvalid(rvalid), .iout_tel(iout_tel), .temp_tel(temp_tel),
    .max_current_setting(16'h0010), .alert_output_pin(alert),
    .regulator_fault_pin(fault_pin), .output_enable(oe));
  host_model host_u (.core_clk(core_clk), .cmd_rdata(rdata), .cmd_rvalid(rvalid),
    .cmd(cmd), .iout_tel(iout_tel), .temp_tel(temp_tel));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    host_u.read(code, rd);
    chk("read data", exp, rd);
  endtask : rd_chk

  // Alert, fault pin, output enable
  task automatic pins(input logic [2:0] exp);
    #1;
    chk("pins", {13'h0000, exp}, {13'h0000, alert, fault_pin, oe});
    @(posedge core_clk);
  endtask : pins

  task automatic results();
    $display("Checks made %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    #200000;
    bad_count++;
    results();
  end

  initial begin
    ce = 1'b1;
    reset = 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    pins(3'b001);
    rd_chk(CMD_TEMP_FAULT_LIMIT, 16'h007D);
    rd_chk(CMD_IOUT_WARN_LIMIT, 16'h0010);
    host_u.send(1'b1, CMD_TEMP_FAULT_ACTION, 16'h1234);
    rd_chk(CMD_TEMP_FAULT_ACTION, 16'h00F8);
    host_u.send(1'b1, CMD_TEMP_FAULT_LIMIT, 16'h0064);
    rd_chk(CMD_TEMP_FAULT_LIMIT, 16'h0064);
    // Clock enable low: write and sample must both be ignored
    ce <= 1'b0;
    host_u.send(1'b1, CMD_TEMP_FAULT_LIMIT, 16'h007D);
    host_u.sample(1'b1, 16'h007E);
    pins(3'b001);
    ce <= 1'b1;
    rd_chk(CMD_TEMP_FAULT_LIMIT, 16'h0064);
    host_u.send(1'b1, CMD_TEMP_FAULT_LIMIT, 16'h007D);
    rd_chk(CMD_TEMP_FAULT_LIMIT, 16'h007D);
    host_u.send(1'b1, CMD_IOUT_WARN_LIMIT, 16'hF828);
    rd_chk(CMD_IOUT_WARN_LIMIT, 16'hF828);
    host_u.sample(1'b0, 16'h0014);
    pins(3'b001);
    host_u.sample(1'b0, 16'h0015);
    pins(3'b101);
    host_u.sample(1'b0, 16'h0001);
    pins(3'b101);
    rd_chk(CMD_STATUS_BYTE, 16'h0001);
    rd_chk(CMD_STATUS_WORD, 16'h4001);
    rd_chk(CMD_STATUS_IOUT, 16'h0020);
    host_u.send(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    pins(3'b001);
    host_u.sample(1'b1, 16'h007D);
    pins(3'b001);
    host_u.sample(1'b1, 16'h007E);
    pins(3'b110);
    rd_chk(CMD_STATUS_TEMP, 16'h0080);
    rd_chk(CMD_STATUS_BYTE, 16'h0004);
    host_u.sample(1'b1, 16'h006F);
    pins(3'b110);
    host_u.sample(1'b1, 16'h006E);
    pins(3'b111);
    host_u.send(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    pins(3'b001);
    results();
  end
endmodule : current_temp_limit_monitor_bench
